/* File: tt_map.svh */
// Register offsets, field positions, reset values and divider counts for the timer block.
// Assumes an 8-bit register address space, one byte per address.
`ifndef TT_MAP_SVH
`define TT_MAP_SVH

`define TT_ADDR_CTRL      8'hc8
`define TT_ADDR_CTRL_SET  8'hc0
`define TT_ADDR_CTRL_CLR  8'hc1
`define TT_ADDR_RLD_LO    8'hca
`define TT_ADDR_RLD_HI    8'hcb
`define TT_ADDR_CNT_LO    8'hcc
`define TT_ADDR_CNT_HI    8'hcd
`define TT_ADDR_CLKCTL    8'h8e
`define TT_ADDR_IRQ_STAT  8'he0
`define TT_ADDR_IRQ_MASK  8'he1

`define TT_CLK_LO_SEL_BIT 0
`define TT_CLK_HI_SEL_BIT 1

`define TT_IRQ_HI_BIT     0
`define TT_IRQ_LO_BIT     1
`define TT_IRQ_CAP_BIT    2

`define TT_CTRL_RESET     8'h00
`define TT_CLKCTL_RESET   8'h00
`define TT_CNT_RESET      16'h0000
`define TT_RLD_RESET      16'h0000
`define TT_IRQ_RESET      3'h0

`define TT_SYS_DIV        12
`define TT_EXT_DIV        8

`endif

/* File: tt_pkg.sv */
// Types shared by the timer block files.
// Assumes nothing outside this package.
`default_nettype none
package tt_pkg;

  typedef struct packed {
    logic hi_flag;
    logic lo_flag;
    logic lo_ie;
    logic cap_en;
    logic split;
    logic run;
    logic unused;
    logic xclk;
  } tt_ctrl_t;

  typedef struct packed {
    logic div12;
    logic ext8;
    logic lfo_fall;
  } tt_ticks_t;

  typedef enum logic [1:0] {
    TT_MODE_16    = 2'b01,
    TT_MODE_SPLIT = 2'b10
  } tt_mode_t;

endpackage
`default_nettype wire

/* File: tt_tick.sv */
// Clock prescalers and pin synchronisers for the timer.
// Assumes ext_clk and lfo pins are asynchronous to clk and slower than clk/2.
`timescale 1ns/1ps
`default_nettype none
`include "tt_map.svh"

module tt_tick
#(
  parameter int SYS_DIV = `TT_SYS_DIV,
  parameter int EXT_DIV = `TT_EXT_DIV
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Pins
  input  wire logic        ext_clk_pin,
  input  wire logic        lfo_pin,
  // Enables
  output var tt_pkg::tt_ticks_t ticks
);
  import tt_pkg::*;

  logic [2:0]       ext_sync_ff;
  logic [2:0]       lfo_sync_ff;
  logic [3:0]       sys_cnt_ff;
  logic [2:0]       ext_cnt_ff;
  tt_ticks_t        ticks_ff;
  logic [2:0]       nxt_ext_sync;
  logic [2:0]       nxt_lfo_sync;
  logic [3:0]       nxt_sys_cnt;
  logic [2:0]       nxt_ext_cnt;
  tt_ticks_t        nxt_ticks;
  logic             ext_rise;

  always_comb
  begin
    nxt_ext_sync = {ext_sync_ff[1:0], ext_clk_pin};
    nxt_lfo_sync = {lfo_sync_ff[1:0], lfo_pin};
    // Edges are judged only from the second and third stages.
    ext_rise     = ext_sync_ff[1] & ~ext_sync_ff[2];
    nxt_ticks    = '0;
    if (sys_cnt_ff == 4'(SYS_DIV - 1))
    begin
      nxt_sys_cnt     = 4'h0;
      nxt_ticks.div12 = 1'b1;
    end
    else
    begin
      nxt_sys_cnt = sys_cnt_ff + 4'h1;
    end
    nxt_ext_cnt = ext_cnt_ff;
    if (ext_rise)
    begin
      if (ext_cnt_ff == 3'(EXT_DIV - 1))
      begin
        nxt_ext_cnt    = 3'h0;
        nxt_ticks.ext8 = 1'b1;
      end
      else
      begin
        nxt_ext_cnt = ext_cnt_ff + 3'h1;
      end
    end
    nxt_ticks.lfo_fall = ~lfo_sync_ff[1] & lfo_sync_ff[2];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_sync_ff <= 3'h0;
      lfo_sync_ff <= 3'h0;
      sys_cnt_ff  <= 4'h0;
      ext_cnt_ff  <= 3'h0;
      ticks_ff    <= '0;
    end
    else
    begin
      ext_sync_ff <= nxt_ext_sync;
      lfo_sync_ff <= nxt_lfo_sync;
      sys_cnt_ff  <= nxt_sys_cnt;
      ext_cnt_ff  <= nxt_ext_cnt;
      ticks_ff    <= nxt_ticks;
    end
  end

  assign ticks = ticks_ff;

endmodule
`default_nettype wire

/* File: tt_timer.sv */
// Timer with 16-bit or dual 8-bit auto-reload counting, overflow flags,
// oscillator capture and a sticky interrupt status register.
// Assumes a single-cycle register port with read data one cycle after the strobe.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tt_map.svh"

module tt_timer
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Pins
  input  wire logic       ext_clk,
  input  wire logic       lfo_out,
  // Interrupt
  output logic            irq
);
  import tt_pkg::*;

  tt_ticks_t   tk;
  tt_ctrl_t    ctrl_ff;
  logic [15:0] cnt_ff;
  logic [15:0] rld_ff;
  logic [7:0]  clkctl_ff;
  logic [2:0]  stat_ff;
  logic [2:0]  mask_ff;
  logic [7:0]  rdata_ff;
  tt_ctrl_t    nxt_ctrl;
  logic [15:0] nxt_cnt;
  logic [15:0] nxt_rld;
  logic [7:0]  nxt_clkctl;
  logic [2:0]  nxt_stat;
  logic [2:0]  nxt_mask;
  logic [7:0]  nxt_rdata;
  tt_mode_t    mode;
  logic        tick_lo;
  logic        tick_hi;
  logic        ev_hi;
  logic        ev_lo;
  logic        ev_cap;
  logic        wr_ctrl;

  tt_tick u_tick
  (
    .clk         (clk),
    .nrst        (nrst),
    .ext_clk_pin (ext_clk),
    .lfo_pin     (lfo_out),
    .ticks       (tk)
  );

  // Counting group.
  always_comb
  begin
    tick_lo = clkctl_ff[`TT_CLK_LO_SEL_BIT] ? 1'b1 : (ctrl_ff.xclk ? tk.ext8 : tk.div12);
    tick_hi = clkctl_ff[`TT_CLK_HI_SEL_BIT] ? 1'b1 : (ctrl_ff.xclk ? tk.ext8 : tk.div12);
    mode    = ctrl_ff.split ? TT_MODE_SPLIT : TT_MODE_16;
    nxt_cnt = cnt_ff;
    ev_hi   = 1'b0;
    ev_lo   = 1'b0;
    unique case (mode)
      TT_MODE_16:
      begin
        if (ctrl_ff.run && tick_lo)
        begin
          if (cnt_ff[7:0] == 8'hff)
          begin
            ev_lo = 1'b1;
          end
          if (cnt_ff == 16'hffff)
          begin
            ev_hi = 1'b1;
            nxt_cnt = rld_ff;
          end
          else
          begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
      end
      TT_MODE_SPLIT:
      begin
        if (tick_lo)
        begin
          if (cnt_ff[7:0] == 8'hff)
          begin
            ev_lo = 1'b1;
            nxt_cnt[7:0] = rld_ff[7:0];
          end
          else
          begin
            nxt_cnt[7:0] = cnt_ff[7:0] + 8'h01;
          end
        end
        if (ctrl_ff.run && tick_hi)
        begin
          if (cnt_ff[15:8] == 8'hff)
          begin
            ev_hi = 1'b1;
            nxt_cnt[15:8] = rld_ff[15:8];
          end
          else
          begin
            nxt_cnt[15:8] = cnt_ff[15:8] + 8'h01;
          end
        end
      end
    endcase
    // Software loads of the count take over from counting in the same cycle.
    if (wr && addr == `TT_ADDR_CNT_LO)
    begin
      nxt_cnt[7:0] = wdata;
    end
    if (wr && addr == `TT_ADDR_CNT_HI)
    begin
      nxt_cnt[15:8] = wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= `TT_CNT_RESET;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Reload and capture group.
  always_comb
  begin
    ev_cap  = ctrl_ff.cap_en & tk.lfo_fall;
    nxt_rld = rld_ff;
    if (wr && addr == `TT_ADDR_RLD_LO)
    begin
      nxt_rld[7:0] = wdata;
    end
    if (wr && addr == `TT_ADDR_RLD_HI)
    begin
      nxt_rld[15:8] = wdata;
    end
    // Capture is a hardware event, so it wins over a software write.
    // capture copy
    if (ev_cap)
    begin
      nxt_rld = cnt_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rld_ff <= `TT_RLD_RESET;
    end
    else
    begin
      rld_ff <= nxt_rld;
    end
  end

  // Control and clock control group.
  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_clkctl = clkctl_ff;
    wr_ctrl    = wr && addr == `TT_ADDR_CTRL;
    if (wr_ctrl)
    begin
      nxt_ctrl = tt_ctrl_t'(wdata);
    end
    if (wr && addr == `TT_ADDR_CTRL_SET)
    begin
      nxt_ctrl = tt_ctrl_t'(ctrl_ff | wdata);
    end
    if (wr && addr == `TT_ADDR_CTRL_CLR)
    begin
      nxt_ctrl = tt_ctrl_t'(ctrl_ff & ~wdata);
    end
    nxt_ctrl.unused = 1'b0;
    // sticky flags, set beats a clearing write
    if (ev_hi)
    begin
      nxt_ctrl.hi_flag = 1'b1;
    end
    if (ev_lo)
    begin
      nxt_ctrl.lo_flag = 1'b1;
    end
    if (wr && addr == `TT_ADDR_CLKCTL)
    begin
      nxt_clkctl = wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff   <= tt_ctrl_t'(`TT_CTRL_RESET);
      clkctl_ff <= `TT_CLKCTL_RESET;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      clkctl_ff <= nxt_clkctl;
    end
  end

  // Interrupt group: status bits are write-one-to-clear, mask acts as interrupt enable.
  always_comb
  begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    if (wr && addr == `TT_ADDR_IRQ_STAT)
    begin
      nxt_stat = stat_ff & ~wdata[2:0];
    end
    if (wr && addr == `TT_ADDR_IRQ_MASK)
    begin
      nxt_mask = wdata[2:0];
    end
    if (ev_hi)
    begin
      nxt_stat[`TT_IRQ_HI_BIT] = 1'b1;
    end
    if (ev_lo && ctrl_ff.lo_ie)
    begin
      nxt_stat[`TT_IRQ_LO_BIT] = 1'b1;
    end
    if (ev_cap)
    begin
      nxt_stat[`TT_IRQ_CAP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_ff <= `TT_IRQ_RESET;
      mask_ff <= `TT_IRQ_RESET;
    end
    else
    begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // Read group: unmapped addresses read zero.
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `TT_ADDR_CTRL,
        `TT_ADDR_CTRL_SET,
        `TT_ADDR_CTRL_CLR: nxt_rdata = ctrl_ff;
        `TT_ADDR_RLD_LO:   nxt_rdata = rld_ff[7:0];
        `TT_ADDR_RLD_HI:   nxt_rdata = rld_ff[15:8];
        `TT_ADDR_CNT_LO:   nxt_rdata = cnt_ff[7:0];
        `TT_ADDR_CNT_HI:   nxt_rdata = cnt_ff[15:8];
        `TT_ADDR_CLKCTL:   nxt_rdata = clkctl_ff;
        `TT_ADDR_IRQ_STAT: nxt_rdata = {5'h00, stat_ff};
        `TT_ADDR_IRQ_MASK: nxt_rdata = {5'h00, mask_ff};
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

endmodule
`default_nettype wire

/* File: tt_chk.sv */
// Assertions on the timer register port and interrupt line.
// Assumes it is bound to tt_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tt_chk
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Pins
  input wire logic       ext_clk,
  input wire logic       lfo_out,
  input wire logic       irq
);
  logic [2:0] mask_ff;
  logic [2:0] nxt_mask;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Shadow of the mask, so that the interrupt can be tied to its enable.
  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr && addr == 8'he1)
      nxt_mask = wdata[2:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mask_ff <= 3'h0;
    else
      mask_ff <= nxt_mask;
  end

  sequence s_ctrl_wr_rd;
    wr && addr == 8'hc8 ##2 rd && addr == 8'hc8;
  endsequence

  sequence s_rld_wr_rd;
    wr && addr == 8'hca ##2 rd && addr == 8'hca;
  endsequence

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero");
  a_ctrl_bit1_zero: assert property (rd && addr == 8'hc8 |=> !rdata[1])
    else $error("control bit 1 not zero");
  a_ctrl_readback: assert property (s_ctrl_wr_rd |=> (rdata & 8'h3d) == ($past(wdata, 3) & 8'h3d))
    else $error("control readback wrong");
  a_rld_readback: assert property (s_rld_wr_rd |=> rdata == $past(wdata, 3))
    else $error("reload readback wrong");
  a_unmapped_zero: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_needs_mask: assert property (irq |-> mask_ff != 3'h0)
    else $error("interrupt while masked");
  a_irq_sticky: assert property (irq && !wr |=> irq)
    else $error("interrupt dropped by itself");
  a_mask_off: assert property (wr && addr == 8'he1 && wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt after mask cleared");
endmodule

bind tt_timer tt_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ext_clk(ext_clk), .lfo_out(lfo_out), .irq(irq));
`default_nettype wire

/* File: tt_osc_model.sv */
// Oscillator and external clock pins on the timer's far side.
// Assumes the bench asks for a burst count or one falling edge.
`timescale 1ns/1ps
`default_nettype none
module tt_osc_model
(
  // Commands
  input  wire logic [4:0] n_ext,
  input  wire logic       fall,
  // Pins
  output logic            ext_clk,
  output logic            lfo_out
);
  initial
  begin
    ext_clk = 1'b0;
    lfo_out = 1'b1;
  end

  // The low phase spans many clocks so the synchroniser cannot miss it.
  always @(posedge fall)
  begin
    lfo_out = 1'b0;
    #1500 lfo_out = 1'b1;
  end

  // The external clock stands still outside a burst.
  always @(n_ext)
    repeat (n_ext)
    begin
      #230 ext_clk = 1'b1;
      #230 ext_clk = 1'b0;
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for tt_timer.
// Assumes the oscillator model drives the two pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       nrst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ext_clk;
  logic       lfo_out;
  logic       irq;
  logic [4:0] n_ext;
  logic       fall;
  int         n_fail;
  int         checks;
  int         cyc;

  tt_timer dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_clk(ext_clk), .lfo_out(lfo_out), .irq(irq));
  tt_osc_model osc (.n_ext(n_ext), .fall(fall), .ext_clk(ext_clk), .lfo_out(lfo_out));

  always #50 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata & m, e);
  endtask

  task automatic wirq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    cmp({7'h00, irq}, 8'h01);
  endtask

  task automatic t_reset;
    rchk(8'hc8, 8'hff, 8'h00);
    rchk(8'hcc, 8'hff, 8'h00);
    rchk(8'hcb, 8'hff, 8'h00);
    rchk(8'h00, 8'hff, 8'h00);
  endtask

  task automatic t_ctrl;
    wreg(8'hc8, 8'h3b);
    rchk(8'hc8, 8'hff, 8'h39);
    wreg(8'hc0, 8'h04);
    rchk(8'hc8, 8'hff, 8'h3d);
    wreg(8'hc1, 8'h3d);
    rchk(8'hc8, 8'hff, 8'h00);
  endtask

  // The run bit is held for exactly 120 clocks, ten divide-by-12 ticks.
  task automatic t_sys12;
    wreg(8'hcc, 8'h00);
    wreg(8'hcd, 8'h00);
    wreg(8'hc8, 8'h04);
    repeat (118) @(posedge clk);
    wreg(8'hc1, 8'h04);
    rchk(8'hcc, 8'hff, 8'h0a);
  endtask

  task automatic t_wrap16;
    wreg(8'hca, 8'hfe);
    rchk(8'hca, 8'hff, 8'hfe);
    wreg(8'hcb, 8'hff);
    wreg(8'hcc, 8'hfe);
    wreg(8'hcd, 8'hff);
    wreg(8'he1, 8'h03);
    wreg(8'hc8, 8'h24);
    wirq(40);
    wreg(8'hc1, 8'h04);
    rchk(8'hcc, 8'hff, 8'hfe);
    repeat (30) @(posedge clk);
    rchk(8'hc8, 8'hc0, 8'hc0);
    rchk(8'he0, 8'h07, 8'h03);
    wreg(8'hc8, 8'h00);
    rchk(8'hc8, 8'hc0, 8'h00);
    wreg(8'he0, 8'h07);
    #1;
    cmp({7'h00, irq}, 8'h00);
  endtask

  task automatic t_split;
    wreg(8'h8e, 8'h01);
    wreg(8'hcd, 8'h10);
    wreg(8'hcc, 8'hff);
    wreg(8'hca, 8'h80);
    wreg(8'hc8, 8'h08);
    rchk(8'hcd, 8'hff, 8'h10);
    rchk(8'hc8, 8'hc0, 8'h40);
    rchk(8'he0, 8'h02, 8'h00);
    rchk(8'hcc, 8'hf0, 8'h80);
    wreg(8'hcd, 8'hff);
    wreg(8'h8e, 8'h03);
    wreg(8'hc0, 8'h04);
    rchk(8'hc8, 8'h80, 8'h80);
    wreg(8'hc8, 8'h00);
    wreg(8'h8e, 8'h00);
    wreg(8'he0, 8'h07);
  endtask

  task automatic t_capture;
    wreg(8'hcc, 8'h34);
    wreg(8'hcd, 8'h12);
    wreg(8'he1, 8'h04);
    wreg(8'hc8, 8'h10);
    fall <= 1'b1;
    wirq(30);
    rchk(8'hca, 8'hff, 8'h34);
    rchk(8'hcb, 8'hff, 8'h12);
    wreg(8'he1, 8'h00);
    #1;
    cmp({7'h00, irq}, 8'h00);
    wreg(8'he0, 8'h07);
    wreg(8'hc8, 8'h00);
  endtask

  task automatic t_ext;
    wreg(8'hcc, 8'h00);
    wreg(8'hcd, 8'h00);
    wreg(8'hc8, 8'h05);
    n_ext <= 5'h10;
    repeat (90) @(posedge clk);
    rchk(8'hcc, 8'hff, 8'h02);
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    n_ext = 5'h00;
    fall = 1'b0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_ctrl;
    t_sys12;
    t_wrap16;
    t_split;
    t_capture;
    t_ext;
    tally_and_finish;
  end
endmodule
`default_nettype wire
